//--- hw/ohci_mode_control_regs.sv
// Version and operating-mode control registers of a USB host controller.
// Assumes a word-wide register port on core_clk_i, a list engine and a
// status register outside that talk to it through pulses and levels.
`timescale 1ns/1ps
module ohci_mode_control_regs #(
	parameter int SOF_DELAY_CYCLES = ohci_mode_pkg::SOF_DELAY_CYCLES,
	parameter int FRAME_CYCLES = ohci_mode_pkg::FRAME_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [ohci_mode_pkg::ADDR_WIDTH-1:0] reg_addr_i,
	input wire logic [ohci_mode_pkg::DATA_WIDTH-1:0] reg_wdata_i,
	output logic [ohci_mode_pkg::DATA_WIDTH-1:0] reg_rdata_o,
	output logic reg_rvalid_o,
	input wire logic sw_reset_i,
	input wire logic port_resume_i,
	input wire logic resume_flag_clr_i,
	input wire logic frame_flag_clr_i,
	input wire logic irq_pending_i,
	input wire logic iso_desc_seen_i,
	input wire logic np_decide_i,
	input wire logic ctrl_served_i,
	output logic resume_flag_o,
	output logic frame_flag_o,
	output logic sof_pulse_o,
	output logic remote_wake_o,
	output logic host_irq_o,
	output logic sysmgmt_irq_o,
	output ohci_mode_pkg::list_enables_t list_en_o,
	output logic iso_continue_o,
	output logic periodic_halt_o,
	output logic np_decide_valid_o,
	output logic np_serve_ctrl_o,
	output logic [1:0] functional_state_o,
	output logic root_hub_reset_o,
	output logic port_reset_o
);

	localparam logic [ohci_mode_pkg::TIMER_WIDTH-1:0] SOF_LOAD =
		ohci_mode_pkg::TIMER_WIDTH'(SOF_DELAY_CYCLES - 1);
	localparam logic [ohci_mode_pkg::TIMER_WIDTH-1:0] FRAME_LOAD =
		ohci_mode_pkg::TIMER_WIDTH'(FRAME_CYCLES - 1);

	ohci_mode_pkg::mode_ctrl_t ctrl_r;
	ohci_mode_pkg::mode_ctrl_t ctrl_nxt;
	ohci_mode_pkg::mode_ctrl_t wr_fields;
	logic ctrl_wr;
	logic resume_level;
	logic resume_prev_r;
	logic resume_prev_nxt;
	logic resume_rise;

	// ----------------------------------------------------------------
	// Port resume input
	// ----------------------------------------------------------------
	resume_sync u_resume_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.async_i(port_resume_i),
		.level_o(resume_level)
	);

	always_comb begin
		resume_prev_nxt = resume_level;
	end

	// Only the edge counts, so a software selected resume never sets it.
	assign resume_rise = resume_level && !resume_prev_r;

	// ----------------------------------------------------------------
	// Mode-control register
	// ----------------------------------------------------------------
	assign ctrl_wr = reg_wr_i && (reg_addr_i == ohci_mode_pkg::CONTROL_OFFSET);
	// Only the eleven defined bits are taken; the rest of the word is lost.
	assign wr_fields = ohci_mode_pkg::mode_ctrl_t'(
		reg_wdata_i[ohci_mode_pkg::CONTROL_WIDTH-1:0]);

	always_comb begin
		ctrl_nxt = ctrl_r;
		if (ctrl_wr) begin
			ctrl_nxt = wr_fields;
		end else if (ctrl_r.functional_state ==
			ohci_mode_pkg::state_suspend && resume_rise) begin
			ctrl_nxt.functional_state = ohci_mode_pkg::state_resume;
		end
		// Soft reset wins over a write in the same cycle.
		if (sw_reset_i) begin
			ctrl_nxt = ohci_mode_pkg::MODE_CTRL_RESET;
			ctrl_nxt.wake_wired = ctrl_r.wake_wired;
			ctrl_nxt.irq_to_sysmgmt = ctrl_r.irq_to_sysmgmt;
			ctrl_nxt.functional_state = ohci_mode_pkg::state_suspend;
		end
	end

	// Hardware reset lands in the reset state with every field clear.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_r <= ohci_mode_pkg::MODE_CTRL_RESET;
			resume_prev_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			resume_prev_r <= resume_prev_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Frame timer
	// ----------------------------------------------------------------
	logic [ohci_mode_pkg::TIMER_WIDTH-1:0] timer_r;
	logic [ohci_mode_pkg::TIMER_WIDTH-1:0] timer_nxt;
	logic was_running_r;
	logic was_running_nxt;
	logic running;
	logic frame_start;

	assign running = (ctrl_r.functional_state == ohci_mode_pkg::state_running);

	always_comb begin
		timer_nxt = timer_r;
		frame_start = 1'b0;
		was_running_nxt = running;
		if (!running) begin
			timer_nxt = '0;
		end else if (!was_running_r) begin
			timer_nxt = SOF_LOAD;
		end else if (timer_r == '0) begin
			frame_start = 1'b1;
			timer_nxt = FRAME_LOAD;
		end else begin
			timer_nxt = timer_r - 16'h0001;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			timer_r <= '0;
			was_running_r <= 1'b0;
		end else begin
			timer_r <= timer_nxt;
			was_running_r <= was_running_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Per-frame list enables
	// ----------------------------------------------------------------
	// Enables are copied only at a frame start and cleared at once by soft reset,
	// so a register write made mid-frame waits for the next one in both directions.
	ohci_mode_pkg::list_enables_t list_en_r;
	ohci_mode_pkg::list_enables_t list_en_nxt;
	logic iso_continue_r;
	logic iso_continue_nxt;
	logic periodic_halt_r;
	logic periodic_halt_nxt;

	always_comb begin
		list_en_nxt = list_en_r;
		if (frame_start) begin
			list_en_nxt.bulk = ctrl_r.bulk_list_enable;
			list_en_nxt.ctrl = ctrl_r.ctrl_list_enable;
			list_en_nxt.iso = ctrl_r.iso_enable;
			list_en_nxt.periodic = ctrl_r.periodic_list_enable;
		end
		if (sw_reset_i) begin
			list_en_nxt = ohci_mode_pkg::LIST_ENABLES_OFF;
		end
		iso_continue_nxt = iso_desc_seen_i && list_en_r.iso;
		periodic_halt_nxt = iso_desc_seen_i && !list_en_r.iso;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			list_en_r <= ohci_mode_pkg::LIST_ENABLES_OFF;
			iso_continue_r <= 1'b0;
			periodic_halt_r <= 1'b0;
		end else begin
			list_en_r <= list_en_nxt;
			iso_continue_r <= iso_continue_nxt;
			periodic_halt_r <= periodic_halt_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Nonperiodic arbitration
	// ----------------------------------------------------------------
	ctrl_bulk_arbiter u_arbiter (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.clear_i(sw_reset_i),
		.ratio_i(ctrl_r.ctrl_bulk_ratio),
		.decide_i(np_decide_i),
		.ctrl_served_i(ctrl_served_i),
		.decide_valid_o(np_decide_valid_o),
		.serve_ctrl_o(np_serve_ctrl_o)
	);

	// ----------------------------------------------------------------
	// Event flags
	// ----------------------------------------------------------------
	logic resume_flag_r;
	logic resume_flag_nxt;
	logic frame_flag_r;
	logic frame_flag_nxt;
	logic sof_r;
	logic sof_nxt;

	always_comb begin
		resume_flag_nxt = resume_flag_r;
		if (resume_flag_clr_i) begin
			resume_flag_nxt = 1'b0;
		end
		if (resume_rise) begin
			resume_flag_nxt = 1'b1;
		end
		frame_flag_nxt = frame_flag_r;
		if (frame_flag_clr_i) begin
			frame_flag_nxt = 1'b0;
		end
		if (frame_start) begin
			frame_flag_nxt = 1'b1;
		end
		sof_nxt = frame_start;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			resume_flag_r <= 1'b0;
			frame_flag_r <= 1'b0;
			sof_r <= 1'b0;
		end else begin
			resume_flag_r <= resume_flag_nxt;
			frame_flag_r <= frame_flag_nxt;
			sof_r <= sof_nxt;
		end
	end

	// ----------------------------------------------------------------
	// System signalling
	// ----------------------------------------------------------------
	logic wake_r;
	logic wake_nxt;
	logic host_irq_r;
	logic host_irq_nxt;
	logic sysmgmt_irq_r;
	logic sysmgmt_irq_nxt;
	logic hub_reset_r;
	logic port_reset_r;
	logic port_reset_nxt;

	// Wake enable never touches the interrupt path.
	always_comb begin
		wake_nxt = ctrl_r.wake_enable && resume_flag_r;
		host_irq_nxt = irq_pending_i && !ctrl_r.irq_to_sysmgmt;
		sysmgmt_irq_nxt = irq_pending_i && ctrl_r.irq_to_sysmgmt;
		port_reset_nxt =
			(ctrl_r.functional_state == ohci_mode_pkg::state_reset);
	end

	// The hub reset is held high through hard reset and drops on the first edge after it.
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wake_r <= 1'b0;
			host_irq_r <= 1'b0;
			sysmgmt_irq_r <= 1'b0;
			hub_reset_r <= 1'b1;
			port_reset_r <= 1'b1;
		end else begin
			wake_r <= wake_nxt;
			host_irq_r <= host_irq_nxt;
			sysmgmt_irq_r <= sysmgmt_irq_nxt;
			hub_reset_r <= 1'b0;
			port_reset_r <= port_reset_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [ohci_mode_pkg::DATA_WIDTH-1:0] rdata_r;
	logic [ohci_mode_pkg::DATA_WIDTH-1:0] rdata_nxt;
	logic rvalid_r;
	logic rvalid_nxt;

	always_comb begin
		rdata_nxt = '0;
		rvalid_nxt = reg_rd_i;
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				ohci_mode_pkg::VERSION_OFFSET: begin
					rdata_nxt = {{(ohci_mode_pkg::DATA_WIDTH -
						ohci_mode_pkg::VERSION_WIDTH){1'b0}},
						ohci_mode_pkg::VERSION_VALUE};
				end
				ohci_mode_pkg::CONTROL_OFFSET: begin
					rdata_nxt = {{(ohci_mode_pkg::DATA_WIDTH -
						ohci_mode_pkg::CONTROL_WIDTH){1'b0}},
						ctrl_r};
				end
				default: begin
					rdata_nxt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_r <= '0;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata_o = rdata_r;
	assign reg_rvalid_o = rvalid_r;
	assign resume_flag_o = resume_flag_r;
	assign frame_flag_o = frame_flag_r;
	assign sof_pulse_o = sof_r;
	assign remote_wake_o = wake_r;
	assign host_irq_o = host_irq_r;
	assign sysmgmt_irq_o = sysmgmt_irq_r;
	assign list_en_o = list_en_r;
	assign iso_continue_o = iso_continue_r;
	assign periodic_halt_o = periodic_halt_r;
	assign functional_state_o = ctrl_r.functional_state;
	assign root_hub_reset_o = hub_reset_r;
	assign port_reset_o = port_reset_r;

endmodule

//--- hw/ohci_mode_pkg.sv
// Constants, types and carriers shared by the mode-control register bank.
// Assumes a single 20 MHz core clock and a word-wide register port.
package ohci_mode_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int DATA_WIDTH = 32;
	localparam int ADDR_WIDTH = 8;
	localparam logic [7:0] VERSION_OFFSET = 8'h00;
	localparam logic [7:0] CONTROL_OFFSET = 8'h04;
	localparam logic [7:0] VERSION_VALUE = 8'h10;
	localparam int VERSION_WIDTH = 8;
	localparam int CONTROL_WIDTH = 11;

	// ----------------------------------------------------------------
	// Field layout, bit 10 down to bit 0
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		state_reset = 2'b00,
		state_resume = 2'b01,
		state_running = 2'b10,
		state_suspend = 2'b11
	} functional_state_t;

	typedef struct packed {
		logic wake_enable;
		logic wake_wired;
		logic irq_to_sysmgmt;
		functional_state_t functional_state;
		logic bulk_list_enable;
		logic ctrl_list_enable;
		logic iso_enable;
		logic periodic_list_enable;
		logic [1:0] ctrl_bulk_ratio;
	} mode_ctrl_t;

	localparam mode_ctrl_t MODE_CTRL_RESET = 11'h000;

	// List enables as the list engine sees them for the current frame.
	typedef struct packed {
		logic bulk;
		logic ctrl;
		logic iso;
		logic periodic;
	} list_enables_t;

	localparam list_enables_t LIST_ENABLES_OFF = 4'h0;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int SOF_DELAY_MS = 1;
	localparam int FRAME_MS = 1;
	localparam int SOF_DELAY_CYCLES = CLK_HZ / 1000 * SOF_DELAY_MS;
	localparam int FRAME_CYCLES = CLK_HZ / 1000 * FRAME_MS;
	localparam int TIMER_WIDTH = 16;

	// ----------------------------------------------------------------
	// Control-to-bulk arbitration
	// ----------------------------------------------------------------
	localparam int SERVE_CNT_WIDTH = 3;
	localparam logic [2:0] SERVE_CNT_MAX = 3'h4;

endpackage

//--- hw/resume_sync.sv
// Three-stage synchroniser with agreement filter for a port level.
// Assumes the input is asynchronous to core_clk_i.
`timescale 1ns/1ps
module resume_sync (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic async_i,
	output logic level_o
);

	logic s1_r;
	logic s2_r;
	logic s3_r;
	logic level_r;
	logic level_nxt;

	// ----------------------------------------------------------------
	// Filter
	// ----------------------------------------------------------------
	// A change counts only once the last two stages agree.
	always_comb begin
		level_nxt = level_r;
		if (s2_r == s3_r) begin
			level_nxt = s3_r;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			level_r <= 1'b0;
		end else begin
			s1_r <= async_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			level_r <= level_nxt;
		end
	end

	assign level_o = level_r;

endmodule

//--- hw/ctrl_bulk_arbiter.sv
// Control-to-bulk service arbitration for the nonperiodic lists.
// Assumes the list engine pulses decide_i and ctrl_served_i on core_clk_i.
`timescale 1ns/1ps
module ctrl_bulk_arbiter (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic clear_i,
	input wire logic [1:0] ratio_i,
	input wire logic decide_i,
	input wire logic ctrl_served_i,
	output logic decide_valid_o,
	output logic serve_ctrl_o
);

	logic [ohci_mode_pkg::SERVE_CNT_WIDTH-1:0] count_r;
	logic [ohci_mode_pkg::SERVE_CNT_WIDTH-1:0] count_nxt;
	logic [ohci_mode_pkg::SERVE_CNT_WIDTH-1:0] base;
	logic valid_r;
	logic valid_nxt;
	logic ctrl_r;
	logic ctrl_nxt;
	logic pick_ctrl;

	// ----------------------------------------------------------------
	// Decision
	// ----------------------------------------------------------------
	always_comb begin
		pick_ctrl = (count_r <= {1'b0, ratio_i});
		valid_nxt = decide_i;
		ctrl_nxt = ctrl_r;
		base = count_r;
		if (decide_i) begin
			ctrl_nxt = pick_ctrl;
			if (!pick_ctrl) begin
				base = '0;
			end
		end
		count_nxt = base;
		// The count is never cleared by a frame boundary.
		if (ctrl_served_i && base < ohci_mode_pkg::SERVE_CNT_MAX) begin
			count_nxt = base + 3'h1;
		end
		if (clear_i) begin
			count_nxt = '0;
			ctrl_nxt = 1'b0;
			valid_nxt = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count_r <= '0;
			valid_r <= 1'b0;
			ctrl_r <= 1'b0;
		end else begin
			count_r <= count_nxt;
			valid_r <= valid_nxt;
			ctrl_r <= ctrl_nxt;
		end
	end

	assign decide_valid_o = valid_r;
	assign serve_ctrl_o = ctrl_r;

endmodule

//--- tb/ohci_mode_regs_asserts.sv
// Port checks for the mode-control register bank.
// Assumes it is bound to ohci_mode_control_regs with its counts.
`timescale 1ns/1ps
module ohci_mode_regs_chk #(
	parameter int SOF_DELAY_CYCLES = 4,
	parameter int FRAME_CYCLES = 8
) (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic reg_rvalid_o,
	input wire logic sw_reset_i,
	input wire logic irq_pending_i,
	input wire logic iso_desc_seen_i,
	input wire logic np_decide_i,
	input wire logic resume_flag_o,
	input wire logic frame_flag_o,
	input wire logic sof_pulse_o,
	input wire logic remote_wake_o,
	input wire logic host_irq_o,
	input wire logic sysmgmt_irq_o,
	input wire ohci_mode_pkg::list_enables_t list_en_o,
	input wire logic iso_continue_o,
	input wire logic periodic_halt_o,
	input wire logic np_decide_valid_o,
	input wire logic [1:0] functional_state_o,
	input wire logic port_reset_o
);
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	localparam int SOF_AT = SOF_DELAY_CYCLES + 1;
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	a_version_read: assert property (reg_rd_i && reg_addr_i == 8'h00 |=>
		reg_rvalid_o && reg_rdata_o == 32'h00000010) else $error("version read");
	a_reserved_zero: assert property (reg_rd_i && reg_addr_i != 8'h00 |=>
		reg_rvalid_o && reg_rdata_o[31:11] == 21'h0) else $error("upper bits set");
	a_sof_delay: assert property (functional_state_o == 2'b10 &&
		$past(functional_state_o) != 2'b10 |-> ##[SOF_AT:SOF_AT]
		(sof_pulse_o || functional_state_o != 2'b10)) else $error("first frame");
	a_frame_period: assert property (sof_pulse_o |->
		##[FRAME_CYCLES:FRAME_CYCLES] (sof_pulse_o || functional_state_o != 2'b10))
		else $error("frame period");
	a_flag_with_sof: assert property (sof_pulse_o |-> frame_flag_o)
		else $error("frame flag missing");
	a_wake_needs_flag: assert property (remote_wake_o |-> $past(resume_flag_o))
		else $error("wake without resume");
	a_irq_route: assert property (host_irq_o || sysmgmt_irq_o |->
		$past(irq_pending_i) && !(host_irq_o && sysmgmt_irq_o)) else $error("irq");
	a_hw_state_move: assert property ($changed(functional_state_o) &&
		!$past(reg_wr_i) && !$past(sw_reset_i) |-> $past(functional_state_o)
		== 2'b11 && functional_state_o == 2'b01) else $error("state moved");
	a_soft_reset: assert property (sw_reset_i |=> functional_state_o == 2'b11 &&
		list_en_o == ohci_mode_pkg::LIST_ENABLES_OFF) else $error("soft reset");
	a_port_reset: assert property (port_reset_o ==
		($past(functional_state_o) == 2'b00)) else $error("port reset");
	a_list_latch: assert property ($changed(list_en_o) |->
		sof_pulse_o || $past(sw_reset_i)) else $error("enables moved mid-frame");
	a_iso_decision: assert property (iso_desc_seen_i |=>
		iso_continue_o == $past(list_en_o.iso) &&
		periodic_halt_o == !$past(list_en_o.iso)) else $error("iso decision");
	a_np_answer: assert property (np_decide_i |=> np_decide_valid_o)
		else $error("no arbiter answer");
endmodule

bind ohci_mode_control_regs ohci_mode_regs_chk #(
	.SOF_DELAY_CYCLES(SOF_DELAY_CYCLES), .FRAME_CYCLES(FRAME_CYCLES)
) chk_inst (.core_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
	.reg_rdata_o, .reg_rvalid_o, .sw_reset_i, .irq_pending_i, .iso_desc_seen_i,
	.np_decide_i, .resume_flag_o, .frame_flag_o, .sof_pulse_o, .remote_wake_o,
	.host_irq_o, .sysmgmt_irq_o, .list_en_o, .iso_continue_o, .periodic_halt_o,
	.np_decide_valid_o, .functional_state_o, .port_reset_o);

//--- tb/tb.sv
// Self-checking bench for the mode-control register bank.
// Assumes short frame counts of 4 and 8 cycles at a 50 ns clock.
`timescale 1ns/1ps
module tb;
	logic core_clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h00000000, reg_rdata_o;
	logic sw_reset_i = 1'b0, port_resume_i = 1'b0, resume_flag_clr_i = 1'b0;
	logic frame_flag_clr_i = 1'b0, irq_pending_i = 1'b0, iso_desc_seen_i = 1'b0;
	logic np_decide_i = 1'b0, ctrl_served_i = 1'b0;
	logic reg_rvalid_o, resume_flag_o, frame_flag_o, sof_pulse_o, remote_wake_o;
	logic host_irq_o, sysmgmt_irq_o, iso_continue_o, periodic_halt_o;
	logic np_decide_valid_o, np_serve_ctrl_o, root_hub_reset_o, port_reset_o;
	logic [1:0] functional_state_o;
	ohci_mode_pkg::list_enables_t list_en_o;
	int miscompares = 0;
	int n_checks = 0;

	ohci_mode_control_regs #(.SOF_DELAY_CYCLES(4), .FRAME_CYCLES(8))
	ohci_mode_control_regs_inst (.core_clk_i, .rst_n_i, .reg_wr_i, .reg_rd_i,
		.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .sw_reset_i,
		.port_resume_i, .resume_flag_clr_i, .frame_flag_clr_i, .irq_pending_i,
		.iso_desc_seen_i, .np_decide_i, .ctrl_served_i, .resume_flag_o,
		.frame_flag_o, .sof_pulse_o, .remote_wake_o, .host_irq_o, .sysmgmt_irq_o,
		.list_en_o, .iso_continue_o, .periodic_halt_o, .np_decide_valid_o,
		.np_serve_ctrl_o, .functional_state_o, .root_hub_reset_o, .port_reset_o);

	always #25 core_clk_i = ~core_clk_i;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask

	// Read data is only meaningful in the single cycle after the strobe.
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		d = reg_rdata_o;
		check(reg_rvalid_o, 32'h1);
	endtask

	task automatic wait_sof();
		int i;
		i = 0;
		do begin
			@(posedge core_clk_i);
			#1;
			i++;
		end while (sof_pulse_o !== 1'b1 && i < 40);
		check(sof_pulse_o, 32'h1);
	endtask

	task automatic iso(input logic on);
		@(posedge core_clk_i);
		iso_desc_seen_i <= 1'b1;
		@(posedge core_clk_i);
		iso_desc_seen_i <= 1'b0;
		#1;
		check({iso_continue_o, periodic_halt_o}, {30'h0, on, !on});
	endtask

	task automatic decide(input logic ctl);
		@(posedge core_clk_i);
		np_decide_i <= 1'b1;
		@(posedge core_clk_i);
		np_decide_i <= 1'b0;
		#1;
		check(np_decide_valid_o, 32'h1);
		check(np_serve_ctrl_o, {31'h0, ctl});
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] d;
		#1;
		check(port_reset_o, 32'h1);
		check(functional_state_o, 32'h0);
		rd(8'h00, d);
		check(d, 32'h00000010);
		rd(8'h04, d);
		check(d, 32'h0);
		$display("reset values done");
	endtask

	task automatic t_ignore();
		logic [31:0] d;
		wr(8'h00, 32'hFFFFFFFF);
		rd(8'h00, d);
		check(d, 32'h00000010);
		wr(8'h04, 32'hFFFFFF3F);
		rd(8'h04, d);
		check(d, 32'h0000073F);
		rd(8'h08, d);
		check(d, 32'h0);
		wr(8'h04, 32'h0);
		$display("ignored writes done");
	endtask

	task automatic t_route();
		@(posedge core_clk_i);
		irq_pending_i <= 1'b1;
		wr(8'h04, 32'h00000100);
		repeat (2) @(posedge core_clk_i);
		#1;
		check({host_irq_o, sysmgmt_irq_o}, 32'h1);
		wr(8'h04, 32'h0);
		repeat (2) @(posedge core_clk_i);
		#1;
		check({host_irq_o, sysmgmt_irq_o}, 32'h2);
		@(posedge core_clk_i);
		irq_pending_i <= 1'b0;
		$display("routing done");
	endtask

	task automatic t_run();
		wr(8'h04, 32'h000000BC);
		#1;
		check(list_en_o, 32'h0);
		wait_sof();
		check(list_en_o, 32'hF);
		check(frame_flag_o, 32'h1);
		@(posedge core_clk_i);
		frame_flag_clr_i <= 1'b1;
		@(posedge core_clk_i);
		frame_flag_clr_i <= 1'b0;
		#1;
		check(frame_flag_o, 32'h0);
		wait_sof();
		wr(8'h04, 32'h000000B4);
		iso(1'b1);
		wait_sof();
		check(list_en_o, 32'hD);
		iso(1'b0);
		$display("running done");
	endtask

	// Waiting out a frame between serve and decide shows the count persists.
	task automatic t_ratio();
		for (int r = 0; r < 4; r++) begin
			wr(8'h04, 32'h000000BC | 32'(r));
			for (int k = 0; k <= r; k++) begin
				decide(1'b1);
				@(posedge core_clk_i);
				ctrl_served_i <= 1'b1;
				@(posedge core_clk_i);
				ctrl_served_i <= 1'b0;
			end
			wait_sof();
			decide(1'b0);
		end
		$display("service ratio done");
	endtask

	task automatic t_soft();
		logic [31:0] d;
		wr(8'h04, 32'h000007BC);
		@(posedge core_clk_i);
		sw_reset_i <= 1'b1;
		@(posedge core_clk_i);
		sw_reset_i <= 1'b0;
		#1;
		check(functional_state_o, 32'h3);
		check(list_en_o, 32'h0);
		check(root_hub_reset_o, 32'h0);
		rd(8'h04, d);
		check(d, 32'h000003C0);
		$display("soft reset done");
	endtask

	task automatic t_resume();
		int i;
		wr(8'h04, 32'h000007C0);
		@(posedge core_clk_i);
		port_resume_i <= 1'b1;
		for (i = 0; i < 20 && resume_flag_o !== 1'b1; i++) begin
			@(posedge core_clk_i);
			#1;
		end
		check(resume_flag_o, 32'h1);
		check(functional_state_o, 32'h1);
		@(posedge core_clk_i);
		resume_flag_clr_i <= 1'b1;
		#1;
		check(remote_wake_o, 32'h1);
		@(posedge core_clk_i);
		resume_flag_clr_i <= 1'b0;
		repeat (4) @(posedge core_clk_i);
		port_resume_i <= 1'b0;
		#1;
		check(resume_flag_o, 32'h0);
		repeat (6) @(posedge core_clk_i);
		wr(8'h04, 32'h00000440);
		repeat (6) @(posedge core_clk_i);
		#1;
		check(resume_flag_o, 32'h0);
		check(remote_wake_o, 32'h0);
		$display("resume done");
	endtask

	task automatic t_hard();
		logic [31:0] d;
		wr(8'h04, 32'h00000200);
		rd(8'h04, d);
		check(d, 32'h00000200);
		@(posedge core_clk_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		#1;
		check({root_hub_reset_o, port_reset_o}, 32'h3);
		@(posedge core_clk_i);
		#1;
		check(root_hub_reset_o, 32'h0);
		rd(8'h04, d);
		check(d, 32'h0);
		$display("hard reset done");
	endtask

	initial begin
		repeat (6) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_ignore();
		t_route();
		t_run();
		t_ratio();
		t_soft();
		t_resume();
		t_hard();
		conclude();
	end

	// The whole sequence needs well under 1000 cycles.
	initial begin
		#200000;
		miscompares++;
		conclude();
	end
endmodule
